// ===== smpa_pkg.sv
// constants, types and field layout shared by both link ends
// How it works
// - program address = 6-bit page + low byte
// - shadow RAM address = 6-bit page + byte
// - data/waveform address = 4-bit page + byte
// - host loads page 0x18, then space 100
// - host loads page 0x1A, then space 011
// - host loads page 0x19, then space 001
// - chip select high 4 us between frames
// - page values persist across commands
// - wait states on program fetch at 8 MHz
// - shadow RAM fetch has no wait state
// - fetch redirect only when bit set
// - 2K-byte scratch data RAM in data pages 0-7
// - 512-byte waveform RAM in data pages 8-9
// - lock 0xAA blocks, 0x00 allows access
// - lock resets to the allowing value
// - locked: refuse serial and debugger memory access
// - message buffer reachable while locked
// - debugger lock bit blocks when 1, resets 0
// - tester enables security as last step
// - frame: space, address, write bit, data
// - read data returned in next frame
package smpa_pkg;
	// memory space codes
	localparam logic [2:0] SP_DATA = 3'h1;
	localparam logic [2:0] SP_CTRL = 3'h2;
	localparam logic [2:0] SP_DEV = 3'h3;
	localparam logic [2:0] SP_PROG = 3'h4;
	// control space addresses
	localparam logic [7:0] MSG_BUF_ADDR = 8'h04;
	localparam logic [7:0] PROG_PAGE_ADDR = 8'h18;
	localparam logic [7:0] DATA_PAGE_ADDR = 8'h19;
	localparam logic [7:0] DEV_PAGE_ADDR = 8'h1A;
	localparam logic [7:0] LOCK_ADDR = 8'h40;
	// lock values and reset values
	localparam logic [7:0] LOCK_ON = 8'hAA;
	localparam logic [7:0] LOCK_OFF = 8'h00;
	localparam logic [7:0] LOCK_RESET = 8'h00;
	localparam logic [5:0] PAGE_RESET = 6'h00;
	localparam logic [7:0] RESP_TAG = 8'h05;
	// command field positions
	localparam int CMD_SP_HI = 23;
	localparam int CMD_SP_LO = 21;
	localparam int CMD_AD_HI = 20;
	localparam int CMD_AD_LO = 13;
	localparam int CMD_WR = 12;
	localparam int CMD_DA_HI = 11;
	localparam int CMD_DA_LO = 4;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	// memory sizes
	localparam int MEM14_BYTES = 16384;
	localparam int DATA_BYTES = 2048;
	localparam int WAVE_BYTES = 512;
	localparam logic [11:0] WAVE_BASE = 12'h800;
	localparam logic [11:0] WAVE_END = 12'hA00;
	// control bits from the processor
	localparam int PIC_FETCH_REDIRECT_BIT_BIT = 0;
	localparam int PIC_DBG_BIT = 1;
	localparam logic [1:0] FRAM_WAIT = 2'h1;
	// timing
	localparam int CLK_NS = 40;
	localparam int GAP_NS = 4000;
	localparam int SCK_HALF_NS = 500;
	localparam logic [6:0] GAP_CYCLES = 7'((GAP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0] SCK_HALF_CYCLES = 5'(SCK_HALF_NS / CLK_NS);
	// host register offsets and responses
	localparam logic [3:0] HOST_CMD_OFS = 4'h0;
	localparam logic [3:0] HOST_STAT_OFS = 4'h4;
	localparam logic [3:0] HOST_RESP_OFS = 4'h8;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_SHIFT = 2'b01, HS_TAIL = 2'b10, HS_GAP = 2'b11} smpa_hstate_t;
endpackage

// ===== smpa_link_if.sv
// serial link between host and device
interface smpa_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	modport host (output sck, output cs_n, output mosi, input miso);
	modport dev (input sck, input cs_n, input mosi, output miso);
endinterface

// ===== smpa_sync.sv
// two flip-flop synchroniser for pin inputs
module smpa_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RV = '0
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	logic [W-1:0] meta_reg;
	// first stage feeds only the second
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			meta_reg <= RV;
			Q <= RV;
		end
		else
		begin
			meta_reg <= D;
			Q <= meta_reg;
		end
	end
endmodule

// ===== smpa_dev.sv
// device end: serial slave, page registers, memories, fetch and security lock
module smpa_dev (
	input wire logic MCLK,
	input wire logic RST_N,
	smpa_link_if.dev LINK,
	input wire logic CPU_LOCK_WE,
	input wire logic [7:0] CPU_LOCK_DATA,
	input wire logic CPU_PIC_WE,
	input wire logic [1:0] CPU_PIC_DATA,
	input wire logic CPU_FAST,
	input wire logic FETCH_REQ,
	input wire logic [13:0] FETCH_ADDR,
	output logic FETCH_VALID,
	output logic [7:0] FETCH_DATA,
	input wire logic DBG_REQ,
	input wire logic [13:0] DBG_ADDR,
	output logic DBG_ACK,
	output logic DBG_REFUSED,
	output logic [7:0] DBG_DATA,
	output logic [7:0] MSG_BUF,
	output logic SECURED,
	output logic FETCH_REDIRECT_BIT_ON,
	output logic DEBUG_LOCKED
);
	import smpa_pkg::*;
	logic [7:0] prog_mem [MEM14_BYTES];
	logic [7:0] dev_mem [MEM14_BYTES];
	logic [7:0] data_ram [DATA_BYTES];
	logic [7:0] wave_ram [WAVE_BYTES];
	logic s_sck, s_cs_n, s_mosi;
	logic sck_d_reg, cs_d_reg, miso_reg;
	logic [23:0] in_reg, out_reg, resp_reg, resp_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [5:0] prog_page_reg, dev_page_reg;
	logic [3:0] data_page_reg;
	logic [7:0] msg_reg, lock_reg;
	logic fbusy_reg, fsrc_reg;
	logic [1:0] fwait_reg;
	logic [13:0] faddr_reg;

	// pins pass two flops first
	smpa_sync #(.W(3), .RV(3'b010)) u_sync (
		.MCLK(MCLK),
		.RST_N(RST_N),
		.D({LINK.sck, LINK.cs_n, LINK.mosi}),
		.Q({s_sck, s_cs_n, s_mosi})
	);

	// edge detection on synchronised pins
	wire sck_rise = s_sck & ~sck_d_reg;
	wire sck_fall = ~s_sck & sck_d_reg;
	wire cs_fall = ~s_cs_n & cs_d_reg;
	wire cs_rise = s_cs_n & ~cs_d_reg;
	wire cmd_done = cs_rise & (cnt_reg == FRAME_BITS);

	// command fields
	wire [2:0] cmd_sp = in_reg[CMD_SP_HI:CMD_SP_LO];
	wire [7:0] cmd_ad = in_reg[CMD_AD_HI:CMD_AD_LO];
	wire cmd_wr = in_reg[CMD_WR];
	wire [7:0] cmd_da = in_reg[CMD_DA_HI:CMD_DA_LO];
	wire [7:0] ad0 = {cmd_ad[7:1], 1'b0};
	wire [7:0] ad1 = {cmd_ad[7:1], 1'b1};
	wire is_mem = (cmd_sp == SP_DATA) | (cmd_sp == SP_DEV) | (cmd_sp == SP_PROG);

	// full addresses from page plus low byte
	wire [13:0] prog_wa = {prog_page_reg, cmd_ad};
	wire [13:0] dev_wa = {dev_page_reg, cmd_ad};
	wire [11:0] data_wa = {data_page_reg, cmd_ad};
	wire [13:0] prog_r0 = {prog_page_reg, ad0};
	wire [13:0] prog_r1 = {prog_page_reg, ad1};
	wire [13:0] dev_r0 = {dev_page_reg, ad0};
	wire [13:0] dev_r1 = {dev_page_reg, ad1};
	wire [11:0] data_r0 = {data_page_reg, ad0};
	wire [11:0] data_r1 = {data_page_reg, ad1};

	// memory writes only when unlocked
	wire mem_wr = cmd_done & cmd_wr & ~SECURED;
	wire wr_prog = mem_wr & (cmd_sp == SP_PROG);
	wire wr_dev = mem_wr & (cmd_sp == SP_DEV);
	wire wr_data = mem_wr & (cmd_sp == SP_DATA) & (data_wa < WAVE_BASE);
	wire wr_wave = mem_wr & (cmd_sp == SP_DATA) & (data_wa >= WAVE_BASE) & (data_wa < WAVE_END);
	wire wr_ctrl = cmd_done & cmd_wr & (cmd_sp == SP_CTRL);

	// data and waveform space read, holes read zero
	function automatic logic [7:0] data_rd(input logic [11:0] a);
		if (a < WAVE_BASE)
			data_rd = data_ram[a[10:0]];
		else if (a < WAVE_END)
			data_rd = wave_ram[a[8:0]];
		else
			data_rd = 8'h00;
	endfunction

	// control space read
	function automatic logic [7:0] ctrl_rd(input logic [7:0] a);
		if (a == PROG_PAGE_ADDR)
			ctrl_rd = {2'b00, prog_page_reg};
		else if (a == DATA_PAGE_ADDR)
			ctrl_rd = {4'h0, data_page_reg};
		else if (a == DEV_PAGE_ADDR)
			ctrl_rd = {2'b00, dev_page_reg};
		else if (a == MSG_BUF_ADDR)
			ctrl_rd = msg_reg;
		else if (a == LOCK_ADDR)
			ctrl_rd = lock_reg;
		else
			ctrl_rd = 8'h00;
	endfunction

	// read pair from the aligned address
	wire [15:0] rd_prog = {prog_mem[prog_r0], prog_mem[prog_r1]};
	wire [15:0] rd_dev = {dev_mem[dev_r0], dev_mem[dev_r1]};
	wire [15:0] rd_data = {data_rd(data_r0), data_rd(data_r1)};
	wire [15:0] rd_ctrl = {ctrl_rd(ad0), ctrl_rd(ad1)};
	wire [15:0] rd_sel = (cmd_sp == SP_PROG) ? rd_prog : (cmd_sp == SP_DEV) ? rd_dev :
		(cmd_sp == SP_DATA) ? rd_data : (cmd_sp == SP_CTRL) ? rd_ctrl : 16'h0000;
	wire [15:0] rd_pair = (is_mem & SECURED) ? 16'h0000 : rd_sel;
	assign resp_next = cmd_done ? {RESP_TAG, cmd_wr ? 16'h0000 : rd_pair} : resp_reg;
	assign cnt_next = (cnt_reg == FRAME_BITS) ? cnt_reg : cnt_reg + 5'h01;

	// memory arrays, no reset
	always_ff @(posedge MCLK)
	begin
		if (wr_prog)
			prog_mem[prog_wa] <= cmd_da;
		if (wr_dev)
			dev_mem[dev_wa] <= cmd_da;
		if (wr_data)
			data_ram[data_wa[10:0]] <= cmd_da;
		if (wr_wave)
			wave_ram[data_wa[8:0]] <= cmd_da;
	end

	// edge history and response latch
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			sck_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
			resp_reg <= 24'h000000;
		end
		else
		begin
			sck_d_reg <= s_sck;
			cs_d_reg <= s_cs_n;
			resp_reg <= resp_next;
		end
	end

	// shifting: out on rising sck, in on falling sck
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			in_reg <= 24'h000000;
			out_reg <= 24'h000000;
			cnt_reg <= 5'h00;
			miso_reg <= 1'b0;
		end
		else if (cs_fall)
		begin
			out_reg <= resp_reg;
			cnt_reg <= 5'h00;
		end
		else if (~s_cs_n & sck_rise)
		begin
			miso_reg <= out_reg[23];
			out_reg <= {out_reg[22:0], 1'b0};
		end
		else if (~s_cs_n & sck_fall)
		begin
			in_reg <= {in_reg[22:0], s_mosi};
			cnt_reg <= cnt_next;
		end
	end
	assign LINK.miso = miso_reg;

	// control space registers; pages kept until rewritten
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			prog_page_reg <= PAGE_RESET;
			dev_page_reg <= PAGE_RESET;
			data_page_reg <= PAGE_RESET[3:0];
			msg_reg <= 8'h00;
		end
		else if (wr_ctrl)
		begin
			if (cmd_ad == PROG_PAGE_ADDR)
				prog_page_reg <= cmd_da[5:0];
			if (cmd_ad == DEV_PAGE_ADDR)
				dev_page_reg <= cmd_da[5:0];
			if (cmd_ad == DATA_PAGE_ADDR)
				data_page_reg <= cmd_da[3:0];
			if (cmd_ad == MSG_BUF_ADDR)
				msg_reg <= cmd_da;
		end
	end

	// processor-written lock, redirect and debugger bits
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			lock_reg <= LOCK_RESET;
			SECURED <= 1'b0;
			FETCH_REDIRECT_BIT_ON <= 1'b0;
			DEBUG_LOCKED <= 1'b0;
		end
		else
		begin
			if (CPU_LOCK_WE & ((CPU_LOCK_DATA == LOCK_ON) | (CPU_LOCK_DATA == LOCK_OFF)))
			begin
				lock_reg <= CPU_LOCK_DATA;
				SECURED <= (CPU_LOCK_DATA == LOCK_ON);
			end
			if (CPU_PIC_WE)
			begin
				FETCH_REDIRECT_BIT_ON <= CPU_PIC_DATA[PIC_FETCH_REDIRECT_BIT_BIT];
				DEBUG_LOCKED <= CPU_PIC_DATA[PIC_DBG_BIT];
			end
		end
	end
	assign MSG_BUF = msg_reg;

	// instruction fetch with source select and wait states
	wire ftake = FETCH_REQ & ~fbusy_reg;
	wire fwait_need = ~FETCH_REDIRECT_BIT_ON & CPU_FAST;
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			fbusy_reg <= 1'b0;
			fsrc_reg <= 1'b0;
			fwait_reg <= 2'h0;
			faddr_reg <= 14'h0000;
			FETCH_VALID <= 1'b0;
			FETCH_DATA <= 8'h00;
		end
		else
		begin
			FETCH_VALID <= 1'b0;
			if (ftake)
			begin
				fbusy_reg <= 1'b1;
				fsrc_reg <= FETCH_REDIRECT_BIT_ON;
				fwait_reg <= fwait_need ? FRAM_WAIT : 2'h0;
				faddr_reg <= FETCH_ADDR;
			end
			else if (fbusy_reg & (fwait_reg != 2'h0))
				fwait_reg <= fwait_reg - 2'h1;
			else if (fbusy_reg)
			begin
				fbusy_reg <= 1'b0;
				FETCH_VALID <= 1'b1;
				FETCH_DATA <= fsrc_reg ? dev_mem[faddr_reg] : prog_mem[faddr_reg];
			end
		end
	end

	// debugger read of program memory
	wire dbg_block = SECURED | DEBUG_LOCKED;
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			DBG_ACK <= 1'b0;
			DBG_REFUSED <= 1'b0;
			DBG_DATA <= 8'h00;
		end
		else
		begin
			DBG_ACK <= DBG_REQ & ~dbg_block;
			DBG_REFUSED <= DBG_REQ & dbg_block;
			DBG_DATA <= (DBG_REQ & ~dbg_block) ? prog_mem[DBG_ADDR] : 8'h00;
		end
	end
endmodule

// ===== smpa_host.sv
// host end: AXI4-Lite command registers driving the serial link
module smpa_host (
	input wire logic MCLK,
	input wire logic RST_N,
	smpa_link_if.host LINK,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	import smpa_pkg::*;
	smpa_hstate_t st_reg;
	logic aw_hold_reg, w_hold_reg;
	logic [3:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [23:0] sh_reg, rx_reg, resp_reg;
	logic [4:0] div_reg, bits_reg;
	logic [6:0] gap_reg;
	logic sck_reg, cs_n_reg, mosi_reg, s_miso;

	// miso passes two flops
	smpa_sync #(.W(1), .RV(1'b0)) u_sync (
		.MCLK(MCLK),
		.RST_N(RST_N),
		.D(LINK.miso),
		.Q(s_miso)
	);

	// write channel handshakes and decode
	wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
	wire w_fire = S_AXI_WVALID & S_AXI_WREADY;
	wire do_wr = aw_hold_reg & w_hold_reg & ~S_AXI_BVALID;
	wire aw_hold_next = (aw_hold_reg | aw_fire) & ~do_wr;
	wire w_hold_next = (w_hold_reg | w_fire) & ~do_wr;
	wire idle = (st_reg == HS_IDLE);
	wire cmd_hit = (awaddr_reg == HOST_CMD_OFS);
	wire start = do_wr & cmd_hit & idle;
	wire wr_ok = start | (do_wr & ((awaddr_reg == HOST_STAT_OFS) | (awaddr_reg == HOST_RESP_OFS)));
	wire [23:0] cmd_merged = {wstrb_reg[2] ? wdata_reg[23:16] : 8'h00,
		wstrb_reg[1] ? wdata_reg[15:8] : 8'h00, wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};

	// read decode
	wire ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
	wire rd_stat = (S_AXI_ARADDR == HOST_STAT_OFS);
	wire rd_resp = (S_AXI_ARADDR == HOST_RESP_OFS);
	wire rd_cmd = (S_AXI_ARADDR == HOST_CMD_OFS);
	wire [31:0] rd_val = rd_stat ? {31'h0, ~idle} : rd_resp ? {8'h00, resp_reg} : 32'h0;
	wire rvalid_next = ar_fire | (S_AXI_RVALID & ~S_AXI_RREADY);

	// write channels
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= AXI_OKAY;
		end
		else
		begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			S_AXI_AWREADY <= ~aw_hold_next;
			S_AXI_WREADY <= ~w_hold_next;
			if (aw_fire)
				awaddr_reg <= S_AXI_AWADDR;
			if (w_fire)
			begin
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
			end
			if (do_wr)
			begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? AXI_OKAY : AXI_SLVERR;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// read channel
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= AXI_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= ~rvalid_next;
			S_AXI_RVALID <= rvalid_next;
			if (ar_fire)
			begin
				S_AXI_RDATA <= rd_val;
				S_AXI_RRESP <= (rd_stat | rd_resp | rd_cmd) ? AXI_OKAY : AXI_SLVERR;
			end
		end
	end

	// link sequencer: one frame per command written while idle, shifted out MSB first
	wire half = (div_reg == SCK_HALF_CYCLES - 5'h01);
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			st_reg <= HS_IDLE;
			div_reg <= 5'h00;
			bits_reg <= 5'h00;
			gap_reg <= 7'h00;
			sh_reg <= 24'h0;
			rx_reg <= 24'h0;
			resp_reg <= 24'h0;
			sck_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
		end
		else
		begin
			div_reg <= half ? 5'h00 : div_reg + 5'h01;
			case (st_reg)
				HS_IDLE:
				begin
					div_reg <= 5'h00;
					if (start)
					begin
						sh_reg <= cmd_merged;
						bits_reg <= 5'h00;
						cs_n_reg <= 1'b0;
						st_reg <= HS_SHIFT;
					end
				end
				HS_SHIFT:
					if (half)
					begin
						sck_reg <= ~sck_reg;
						if (!sck_reg)
						begin
							mosi_reg <= sh_reg[23];
							sh_reg <= {sh_reg[22:0], 1'b0};
						end
						else
						begin
							rx_reg <= {rx_reg[22:0], s_miso};
							bits_reg <= bits_reg + 5'h01;
							if (bits_reg == FRAME_BITS - 5'h01)
								st_reg <= HS_TAIL;
						end
					end
				HS_TAIL:
					if (half)
					begin
						cs_n_reg <= 1'b1;
						resp_reg <= rx_reg;
						gap_reg <= 7'h00;
						st_reg <= HS_GAP;
					end
				HS_GAP:
				begin
					gap_reg <= gap_reg + 7'h01;
					if (gap_reg == GAP_CYCLES - 7'h01)
						st_reg <= HS_IDLE;
				end
				default:
					st_reg <= HS_IDLE;
			endcase
		end
	end
	assign LINK.sck = sck_reg;
	assign LINK.cs_n = cs_n_reg;
	assign LINK.mosi = mosi_reg;
endmodule

// ===== smpa_link_assertions.sv
// concurrent checks on the serial link between the two ends
module smpa_link_assertions (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] gap_cnt;
	logic [4:0] hi_cnt;
	logic [4:0] lo_cnt;
	logic [4:0] bit_cnt;
	logic [9:0] len_cnt;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	// cycle counters: idle gap, sck phases, pulses, frame length
	always_ff @(posedge MCLK)
	begin
		gap_cnt <= !RST_N ? 7'h7F : (cs_n ? gap_cnt + 7'(gap_cnt != 7'h7F) : 7'h00);
		hi_cnt <= sck ? hi_cnt + 5'h01 : 5'h00;
		lo_cnt <= (!cs_n && !sck) ? lo_cnt + 5'h01 : 5'h00;
		bit_cnt <= cs_n ? 5'h00 : bit_cnt + 5'(sck && hi_cnt == 5'h00);
		len_cnt <= cs_n ? 10'h000 : len_cnt + 10'h001;
	end
	// framing, clock phases and spacing
	AST_SCK_IDLE: assert property (cs_n |-> !sck)
		else $error("sck moved outside a frame");
	AST_GAP: assert property ($fell(cs_n) |-> gap_cnt >= 7'h64)
		else $error("frame select gap too short");
	AST_SCK_HIGH: assert property ($fell(sck) |-> hi_cnt == 5'h0C)
		else $error("sck high phase length wrong");
	AST_SCK_LOW: assert property ((!cs_n && $rose(sck)) |-> lo_cnt == 5'h0C)
		else $error("sck low phase length wrong");
	AST_PULSES: assert property ($rose(cs_n) |-> bit_cnt == 5'h18)
		else $error("frame without 24 sck pulses");
	AST_FRAME_LEN: assert property ($rose(cs_n) |-> len_cnt == 10'h24C)
		else $error("frame select low for wrong length");
	AST_MOSI_HOLD: assert property ($past(sck) |-> $stable(mosi))
		else $error("mosi changed away from sck rising");
	AST_CS_HOLD: assert property ($fell(cs_n) |-> (!cs_n) [*8])
		else $error("frame select cut short");
	AST_TAIL: assert property (($fell(sck) && bit_cnt == 5'h18) |-> (!cs_n) [*8] ##[1:8] $rose(cs_n))
		else $error("frame select not released after last bit");
	// main scenarios
	COV_START: cover property ($fell(cs_n));
	COV_END: cover property ($rose(cs_n));
	COV_MISO: cover property (!cs_n && miso);
endmodule

// ===== tb_spi_memory_page_access_lock.sv
// self-checking bench: host end driving device end over the serial link
module tb_spi_memory_page_access_lock;
	timeunit 1ns;
	timeprecision 1ps;
	import smpa_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic lock_we = 1'b0;
	logic pic_we = 1'b0;
	logic [7:0] lock_data = 8'h00;
	logic [1:0] pic_data = 2'h0;
	logic cpu_fast = 1'b1;
	logic fetch_req = 1'b0;
	logic [13:0] fetch_addr = 14'h0000;
	logic dbg_req = 1'b0;
	logic [13:0] dbg_addr = 14'h0000;
	logic fetch_valid, dbg_ack, dbg_refused, secured, fetch_redirect_bit_on, debug_locked;
	logic [7:0] fetch_data, dbg_data, msg_buf;
	int fails = 0;
	int comparisons = 0;
	logic [2:0] sp_tab [4] = '{SP_PROG, SP_DEV, SP_DATA, SP_DATA};
	logic [7:0] pa_tab [4] = '{PROG_PAGE_ADDR, DEV_PAGE_ADDR, DATA_PAGE_ADDR, DATA_PAGE_ADDR};
	logic [7:0] pg_tab [4] = '{8'h17, 8'h14, 8'h02, 8'h09};
	logic [7:0] dat_tab [4] = '{8'h12, 8'h35, 8'h5A, 8'hA6};
	smpa_link_if link();
	smpa_host smpa_host_i (.MCLK(mclk), .RST_N(rst_n), .LINK(link), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	smpa_dev smpa_dev_i (.MCLK(mclk), .RST_N(rst_n), .LINK(link), .CPU_LOCK_WE(lock_we),
		.CPU_LOCK_DATA(lock_data), .CPU_PIC_WE(pic_we), .CPU_PIC_DATA(pic_data), .CPU_FAST(cpu_fast),
		.FETCH_REQ(fetch_req), .FETCH_ADDR(fetch_addr), .FETCH_VALID(fetch_valid), .FETCH_DATA(fetch_data),
		.DBG_REQ(dbg_req), .DBG_ADDR(dbg_addr), .DBG_ACK(dbg_ack), .DBG_REFUSED(dbg_refused),
		.DBG_DATA(dbg_data), .MSG_BUF(msg_buf), .SECURED(secured), .FETCH_REDIRECT_BIT_ON(fetch_redirect_bit_on),
		.DEBUG_LOCKED(debug_locked));
	smpa_link_assertions smpa_link_assertions_i (.MCLK(mclk), .RST_N(rst_n), .sck(link.sck),
		.cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
	// clock and watchdog
	initial
	begin
		forever #20 mclk = ~mclk;
	end
	initial
	begin
		repeat (60000) @(posedge mclk);
		fails++;
		end_sim();
	end
	task automatic end_sim;
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// bus cycles: address and data offered together, response awaited
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask
	function automatic logic [23:0] cmd(input logic [2:0] s, input logic [7:0] a, input logic w, input logic [7:0] d);
		return {s, a, w, d, 4'h0};
	endfunction
	// one frame: command, wait for idle, fetch the response
	task automatic xfer(input logic [23:0] c, output logic [23:0] rs);
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(HOST_CMD_OFS, {8'h00, c}, r);
		chk("bresp", 32'(AXI_OKAY), 32'(r));
		axi_wr(HOST_CMD_OFS, {8'h00, c}, r);
		chk("busy bresp", 32'(AXI_SLVERR), 32'(r));
		do
			axi_rd(HOST_STAT_OFS, d, r);
		while (d[0] !== 1'b0);
		axi_rd(HOST_RESP_OFS, d, r);
		chk("rresp", 32'(AXI_OKAY), 32'(r));
		rs = d[23:0];
	endtask
	task automatic rd_chk(input string what, input logic [2:0] s, input logic [7:0] a, input logic [15:0] e);
		logic [23:0] rs;
		xfer(cmd(s, a, 1'b0, 8'h00), rs);
		xfer(cmd(SP_CTRL, MSG_BUF_ADDR, 1'b0, 8'h00), rs);
		chk(what, {8'h00, RESP_TAG, e}, {8'h00, rs});
	endtask
	task automatic cpu_wr(input logic lk, input logic [7:0] d);
		lock_we <= lk;
		pic_we <= !lk;
		lock_data <= d;
		pic_data <= d[1:0];
		@(posedge mclk);
		lock_we <= 1'b0;
		pic_we <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic fetch(input logic [13:0] a, output int lat, output logic [7:0] d);
		fetch_req <= 1'b1;
		fetch_addr <= a;
		@(posedge mclk);
		fetch_req <= 1'b0;
		lat = 0;
		do
		begin
			@(posedge mclk);
			lat++;
		end
		while (fetch_valid !== 1'b1);
		d = fetch_data;
	endtask
	task automatic dbg_chk(input logic ack, input logic rf, input logic [7:0] d);
		dbg_req <= 1'b1;
		dbg_addr <= 14'h1764;
		@(posedge mclk);
		dbg_req <= 1'b0;
		@(posedge mclk);
		chk("debug", {22'h0, ack, rf, d}, {22'h0, dbg_ack, dbg_refused, dbg_data});
	endtask
	// main sequence
	initial
	begin
		logic [23:0] rs;
		int lw, ln, lr;
		logic [7:0] fd;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("lock reset", 32'h0, {30'h0, secured, debug_locked});
		for (int i = 0; i < 4; i++)
		begin
			xfer(cmd(SP_CTRL, pa_tab[i], 1'b1, pg_tab[i]), rs);
			xfer(cmd(sp_tab[i], 8'h64, 1'b1, dat_tab[i]), rs);
			xfer(cmd(sp_tab[i], 8'h65, 1'b1, ~dat_tab[i]), rs);
			rd_chk("mem", sp_tab[i], 8'h64, {dat_tab[i], ~dat_tab[i]});
		end
		xfer(cmd(SP_CTRL, DATA_PAGE_ADDR, 1'b1, 8'h02), rs);
		rd_chk("scratch", SP_DATA, 8'h64, 16'h5AA5);
		rd_chk("prog page kept", SP_PROG, 8'h64, 16'h12ED);
		rd_chk("page readback", SP_CTRL, PROG_PAGE_ADDR, 16'h1702);
		fetch(14'h1764, lw, fd);
		chk("fetch prog", 32'h12, 32'(fd));
		cpu_fast <= 1'b0;
		fetch(14'h1764, ln, fd);
		chk("wait state", 32'(FRAM_WAIT), 32'(lw - ln));
		cpu_fast <= 1'b1;
		cpu_wr(1'b0, 8'h01);
		chk("fetch_redirect_bit", 32'h1, 32'(fetch_redirect_bit_on));
		fetch(14'h1464, lr, fd);
		chk("fetch shadow", 32'h35, 32'(fd));
		chk("shadow latency", 32'(ln), 32'(lr));
		cpu_wr(1'b0, 8'h00);
		cpu_wr(1'b1, LOCK_ON);
		chk("secured", 32'h1, 32'(secured));
		rd_chk("lock readback", SP_CTRL, LOCK_ADDR, {LOCK_ON, 8'h00});
		xfer(cmd(SP_PROG, 8'h64, 1'b1, 8'hEE), rs);
		rd_chk("locked read", SP_PROG, 8'h64, 16'h0000);
		xfer(cmd(SP_CTRL, MSG_BUF_ADDR, 1'b1, 8'h5C), rs);
		chk("message buffer", 32'h5C, 32'(msg_buf));
		dbg_chk(1'b0, 1'b1, 8'h00);
		cpu_wr(1'b1, LOCK_OFF);
		rd_chk("unlocked read", SP_PROG, 8'h64, 16'h12ED);
		dbg_chk(1'b1, 1'b0, 8'h12);
		cpu_wr(1'b0, 8'h02);
		chk("debug lock", 32'h1, 32'(debug_locked));
		dbg_chk(1'b0, 1'b1, 8'h00);
		cpu_wr(1'b0, 8'h00);
		dbg_chk(1'b1, 1'b0, 8'h12);
		end_sim();
	end
endmodule
